// File: seek_settle_offset_control_test.sv
// ssoc testbench: seek, settle, offset, fault and dibit scenarios
module seek_settle_offset_control_test
  import ssoc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PI = 20;
  localparam int PS = 30;
  localparam int PO = 10;
  logic aclk, aresetn, ce, pos_gate_n, neg_gate_n, servo_null, near_track, off_track, half_track;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic integ_clear, cyl_pulse, fine_mode, coarse_mode, servo_invert, heads_select, on_cylinder;
  logic pos_clamp, offset_dir, clk_tick, odd_dibit, even_dibit, travel_limit;
  logic [6:0] pos_conv;
  logic [9:0] offset_uin;
  int fails, n_tests, n_cyl, n_odd, n_even, n_tick;
  ssoc_top #(.P_INHIB(PI), .P_SETTLE(PS), .P_OFFTRK(PO)) DUT (.*);
  ssoc_ctl_model ctl (.*);
  always @(posedge aclk) begin
    n_cyl <= n_cyl + int'(cyl_pulse === 1'b1);
    n_odd <= n_odd + int'(odd_dibit === 1'b1);
    n_even <= n_even + int'(even_dibit === 1'b1);
    n_tick <= n_tick + int'(clk_tick === 1'b1);
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic dib(input logic odd);
    if (odd) pos_gate_n <= 1'b0; else neg_gate_n <= 1'b0;
    cyc(2);
    if (odd) neg_gate_n <= 1'b0; else pos_gate_n <= 1'b0;
    cyc(2);
    pos_gate_n <= 1'b1;
    neg_gate_n <= 1'b1;
    cyc(16);
  endtask
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    ctl.rd(A_STAT, d, r);
    chk("status", d, 32'h0000_0000);
    ctl.rd(A_CNT, d, r);
    chk("count", d, 32'h0000_03ff);
    ctl.rd(8'h18, d, r);
    chk("unmapped", r, RESP_SLVERR);
    $display("test reset done");
  endtask
  task automatic t_dibit();
    int o0, e0, k0;
    o0 = n_odd;
    e0 = n_even;
    k0 = n_tick;
    for (int k = 0; k < 2; k++) begin
      repeat (8) dib(k[0]);
      cyc(4);
      chk("limit set", travel_limit, 1'b1);
    end
    dib(1'b0);
    cyc(4);
    chk("limit clear", travel_limit, 1'b0);
    chk("odd count", n_odd - o0, 8);
    chk("even count", n_even - e0, 9);
    chk("ticks", (n_tick - k0) >= 17, 1'b1);
    $display("test dibit done");
  endtask
  task automatic t_settle();
    logic [31:0] d;
    logic [1:0] r;
    int c0, n;
    ctl.seek(10'h003, 1'b1);
    cyc(4);
    chk("parity", servo_invert, 1'b1);
    c0 = n_cyl;
    repeat (3) begin
      servo_null <= 1'b1;
      cyc(3);
      servo_null <= 1'b0;
      cyc(3);
    end
    cyc(3);
    chk("pulses", n_cyl - c0, 3);
    ctl.rd(A_STAT, d, r);
    chk("stop phase", d[9], 1'b1);
    ctl.rd(A_CNT, d, r);
    chk("counter", d[9:0], CNT_ALL);
    half_track <= 1'b1;
    cyc(4);
    half_track <= 1'b0;
    chk("fine", {fine_mode, coarse_mode}, 2'h2);
    near_track <= 1'b1;
    cyc(PI);
    off_track <= 1'b1;
    cyc(2);
    off_track <= 1'b0;
    ce <= 1'b0;
    cyc(PS + 10);
    chk("ce freeze", on_cylinder, 1'b0);
    ce <= 1'b1;
    n = 0;
    while (on_cylinder !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk("restart", n >= PS - 5, 1'b1);
    chk("settled", on_cylinder, 1'b1);
    $display("test settle done");
  endtask
  task automatic t_offset();
    logic [31:0] d;
    logic [1:0] r;
    ctl.ofs_value(1'b1, 5'h1f);
    cyc(3);
    chk("early value", offset_uin, 10'h000);
    ctl.ofs_ctl(32'h0000_0004);
    ctl.rd(A_OCTL, d, r);
    chk("engaged", d[1], 1'b1);
    ctl.ofs_value(1'b1, 5'h1f);
    cyc(3);
    chk("max offset", offset_uin, 10'h307);
    chk("dir", offset_dir, 1'b1);
    chk("held", pos_conv, 7'h1f);
    ctl.ofs_value(1'b0, 5'h01);
    cyc(3);
    chk("min offset", {offset_dir, offset_uin}, {1'b0, UIN_STEP});
    ctl.ofs_ctl(32'h0000_0080);
    ctl.rd(A_OCTL, d, r);
    chk("released", d[1:0], 2'h0);
    $display("test offset done");
  endtask
  task automatic t_loss();
    logic [31:0] d;
    logic [1:0] r;
    ctl.wr(A_CTRL, 32'h0000_0002, r);
    off_track <= 1'b1;
    cyc(PO - 4);
    off_track <= 1'b0;
    cyc(4);
    chk("short drift", on_cylinder, 1'b1);
    off_track <= 1'b1;
    cyc(PO + 6);
    off_track <= 1'b0;
    cyc(2);
    chk("lost", {on_cylinder, heads_select}, 2'h0);
    ctl.rd(A_STAT, d, r);
    chk("faults", d[4:2], 3'h7);
    $display("test loss done");
  endtask
  task automatic t_clamp();
    logic [9:0] lens [2];
    lens = '{10'h080, 10'h064};
    foreach (lens[i]) begin
      ctl.seek(lens[i], 1'b0);
      cyc(4);
      chk("clamp", pos_clamp, lens[i] >= CLAMP_T);
      chk("conv", pos_conv, (lens[i] >= CLAMP_T) ? POS_MAX : lens[i][6:0]);
      chk("coarse", {on_cylinder, fine_mode, coarse_mode, servo_invert}, 4'h2);
    end
    $display("test clamp done");
  endtask
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    {pos_gate_n, neg_gate_n} = 2'h3;
    {servo_null, near_track, off_track, half_track} = 4'h0;
    cyc(6);
    aresetn <= 1'b1;
    t_reset();
    t_dibit();
    t_settle();
    t_offset();
    t_loss();
    near_track <= 1'b0;
    t_clamp();
    close_out();
  end
  initial begin
    cyc(20000);
    fails++;
    close_out();
  end
endmodule
bind ssoc_top ssoc_chk chk_i (.*);

// File: ssoc_chk.sv
// ssoc checker: port-level properties of the seek settle block
module ssoc_chk
  import ssoc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic integ_clear,
  input wire logic cyl_pulse,
  input wire logic fine_mode,
  input wire logic coarse_mode,
  input wire logic heads_select,
  input wire logic on_cylinder,
  input wire logic [6:0] pos_conv,
  input wire logic pos_clamp,
  input wire logic [9:0] offset_uin,
  input wire logic odd_dibit,
  input wire logic even_dibit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  pulse_clear_a: assert property (cyl_pulse |-> integ_clear)
    else $error("cylinder pulse without integrator clear");
  fine_coarse_a: assert property (fine_mode |-> !coarse_mode)
    else $error("coarse latch held with fine set");
  fine_hold_a: assert property (on_cylinder && fine_mode |=> fine_mode || !on_cylinder)
    else $error("fine mode dropped while settled");
  settled_sel_a: assert property (on_cylinder |-> heads_select)
    else $error("settled with heads deselected");
  ofs_idle_a: assert property (!on_cylinder && $past(!on_cylinder) |-> offset_uin == 10'h000)
    else $error("offset applied while not settled");
  clamp_max_a: assert property (pos_clamp |-> pos_conv == POS_MAX)
    else $error("clamp without maximum converter value");
  single_pulse_a: assert property (cyl_pulse |=> !cyl_pulse)
    else $error("cylinder pulse longer than one cycle");
  dibit_excl_a: assert property (odd_dibit |-> !even_dibit ##1 !even_dibit)
    else $error("odd and even dibit together");
  uin_step_a: assert property (offset_uin % 25 == 0 && offset_uin <= 775)
    else $error("offset displacement off the step grid");
  cover property (on_cylinder && fine_mode);
  cover property (pos_clamp);
  cover property (offset_uin != 10'h000);
endmodule

// File: ssoc_ctl_model.sv
// ssoc controller model: register bus master issuing seek and offset commands
module ssoc_ctl_model
  import ssoc_pkg::*;
(
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic seek(input logic [9:0] len, input logic odd);
    logic [1:0] r;
    wr(A_SEEK, {15'h0000, odd, 6'h00, ~len}, r);
    wr(A_CTRL, 32'h0000_0001, r);
  endtask
  task automatic ofs_value(input logic dir, input logic [4:0] mag);
    logic [1:0] r;
    wr(A_OFS, {24'h00_0000, mag, 2'h0, dir}, r);
  endtask
  task automatic ofs_ctl(input logic [31:0] cmd);
    logic [1:0] r;
    wr(A_OCTL, cmd, r);
  endtask
endmodule

// File: ssoc_dibit.sv
// ssoc dibit decoder: odd/even dibits, machine clock tick, guard bands
module ssoc_dibit
  import ssoc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic pos_sense,
  input wire logic neg_sense,
  output logic odd_dibit,
  output logic even_dibit,
  output logic clk_tick,
  output logic outer_band,
  output logic inner_band,
  output logic travel_limit
);
  localparam logic [3:0] WIN = 4'(DIBIT_CYC);
  logic pos_d;
  logic neg_d;
  logic [3:0] pos_win;
  logic [3:0] neg_win;
  logic [3:0] odd_run;
  logic [3:0] even_run;
  logic pos_rise;
  logic neg_rise;
  logic odd_hit;
  logic even_hit;
  logic hit;
  // gate outputs low on sensing, so a sense rise is a gate fall
  assign pos_rise = pos_sense & ~pos_d; // see R15
  assign neg_rise = neg_sense & ~neg_d;
  assign odd_hit = neg_rise & (pos_win != 4'h0); // see R15
  assign even_hit = pos_rise & (neg_win != 4'h0);
  assign hit = odd_hit | even_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_d <= 1'b0;
      neg_d <= 1'b0;
      pos_win <= 4'h0;
      neg_win <= 4'h0;
    end else if (ce) begin
      pos_d <= pos_sense;
      neg_d <= neg_sense;
      pos_win <= hit ? 4'h0 : pos_rise ? WIN : (pos_win != 4'h0) ? pos_win - 4'h1 : pos_win;
      neg_win <= hit ? 4'h0 : neg_rise ? WIN : (neg_win != 4'h0) ? neg_win - 4'h1 : neg_win;
    end
  end

  // a run of one polarity only means a guard band
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      odd_run <= 4'h0;
      even_run <= 4'h0;
      odd_dibit <= 1'b0;
      even_dibit <= 1'b0;
      clk_tick <= 1'b0;
      outer_band <= 1'b0;
      inner_band <= 1'b0;
      travel_limit <= 1'b0;
    end else if (ce) begin
      odd_run <= even_hit ? 4'h0 : (odd_hit && odd_run != GB_RUN) ? odd_run + 4'h1 : odd_run; // see R14
      even_run <= odd_hit ? 4'h0 : (even_hit && even_run != GB_RUN) ? even_run + 4'h1 : even_run;
      odd_dibit <= odd_hit;
      even_dibit <= even_hit;
      clk_tick <= hit; // see R16
      outer_band <= odd_run == GB_RUN; // see R14
      inner_band <= even_run == GB_RUN;
      travel_limit <= (odd_run == GB_RUN) || (even_run == GB_RUN); // see R16
    end
  end
endmodule

// File: ssoc_pkg.sv
// ssoc package: constants for seek settle and offset control
// Operation
// R1: at one track to go enter stop phase; that cylinder pulse clears the integrator.
// R2: half-track strobe sets fine latch, which releases the coarse latch.
// R3: seek start sets target parity when target is odd; parity picks servo polarity.
// R4: below near threshold after start inhibit, run settle delay, then raise settled.
// R5: fine track following stays active while settled.
// R6: off-track too long drops settled, sets seek failure, deselects heads.
// R7: off-track loss during read or write also sets lockout and fault summary.
// R8: offset value carries direction in bit 0 and magnitude in bits 3 to 7.
// R9: offset value acted on only while settled and after offset begin (bit 2).
// R10: in offset mode counter output held steady at offset magnitude.
// R11: offset engaged (bit 1) rises on offset begin, falls on offset clear (bit 7).
// R12: position converter unclamped below 128 to go, clamped at maximum otherwise.
// R13: exactly one cylinder pulse per cylinder crossed.
// R14: guard bands of single dibit polarity flag a travel limit.
// R15: dibit gates go low on their polarity; falls drive one-shots and flip-flops.
// R16: machine clock and travel-limit enable come from odd and even dibits.
// R17: counter loaded with complement of length, incremented per pulse, all ones is zero.
// R18: overshoot above off-track threshold restarts settle delay from zero.
// R19: magnitude code selects 25 to 775 microinches in steps of 25.
// R20: seek start clears settled and fine latch and returns to coarse mode.
package ssoc_pkg;
  localparam int CLK_NS = 50;
  localparam int INHIB_NS = 4_750_000;
  localparam int SETTLE_NS = 1_750_000;
  localparam int OFFTRK_NS = 800_000;
  localparam int DIBIT_NS = 600;
  localparam int INHIB_CYC = (INHIB_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int OFFTRK_CYC = (OFFTRK_NS + CLK_NS - 1) / CLK_NS;
  localparam int DIBIT_CYC = (DIBIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] GB_RUN = 4'h8;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SEEK = 8'h04;
  localparam logic [7:0] A_OFS = 8'h08;
  localparam logic [7:0] A_OCTL = 8'h0c;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_CNT = 8'h14;
  localparam int F_SEEK_GO = 0;
  localparam int F_RW = 1;
  localparam int F_FCLR = 2;
  localparam int F_TGT_ODD = 16;
  localparam int F_OFS_DIR = 0;
  localparam int F_MAG_LO = 3;
  localparam int F_MAG_HI = 7;
  localparam int F_OFS_BEGIN = 2;
  localparam int F_OFS_CLR = 7;
  localparam logic [9:0] CNT_T1 = 10'h3fe;
  localparam logic [9:0] CNT_ALL = 10'h3ff;
  localparam logic [9:0] CLAMP_T = 10'h080;
  localparam logic [6:0] POS_MAX = 7'h7f;
  localparam logic [9:0] UIN_STEP = 10'h019;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {st_idle, st_seek, st_settle, st_on} ssoc_state_t;
endpackage

// File: ssoc_top.sv
// ssoc top: seek settle, fault, offset control and register slave
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
module ssoc_top
  import ssoc_pkg::*;
#(
  parameter int P_INHIB = INHIB_CYC,
  parameter int P_SETTLE = SETTLE_CYC,
  parameter int P_OFFTRK = OFFTRK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic pos_gate_n,
  input wire logic neg_gate_n,
  input wire logic servo_null,
  input wire logic near_track,
  input wire logic off_track,
  input wire logic half_track,
  output logic integ_clear,
  output logic cyl_pulse,
  output logic fine_mode,
  output logic coarse_mode,
  output logic servo_invert,
  output logic heads_select,
  output logic on_cylinder,
  output logic [6:0] pos_conv,
  output logic pos_clamp,
  output logic offset_dir,
  output logic [9:0] offset_uin,
  output logic clk_tick,
  output logic odd_dibit,
  output logic even_dibit,
  output logic travel_limit
);
  localparam int NS = 6;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] s1;
  logic [NS-1:0] s2;

  // pins pass two flops before use
  assign pin_raw = {half_track, off_track, near_track, servo_null, ~neg_gate_n, ~pos_gate_n};
  for (genvar i = 0; i < NS; i++) begin : g_sync
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s1[i] <= 1'b0;
        s2[i] <= 1'b0;
      end else if (ce) begin
        s1[i] <= pin_raw[i];
        s2[i] <= s1[i];
      end
    end
  end

  logic null_s;
  logic near_s;
  logic off_s;
  logic half_s;
  logic null_d;
  logic half_d;
  assign null_s = s2[2];
  assign near_s = s2[3];
  assign off_s = s2[4];
  assign half_s = s2[5];

  // register slave
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] wm;
  logic [31:0] wd;
  logic do_wr;
  logic wr_ctrl;
  logic wr_seek;
  logic wr_ofs;
  logic wr_octl;
  logic aw_hit;
  logic ar_hit;
  logic [31:0] rd_mux;

  assign awready = ce & ~aw_got & ~bvalid;
  assign wready = ce & ~w_got & ~bvalid;
  assign arready = ce & ~rvalid;
  assign do_wr = ce & aw_got & w_got & ~bvalid;
  assign wm = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign wd = w_data & wm;
  assign wr_ctrl = do_wr && aw_addr == A_CTRL;
  assign wr_seek = do_wr && aw_addr == A_SEEK;
  assign wr_ofs = do_wr && aw_addr == A_OFS;
  assign wr_octl = do_wr && aw_addr == A_OCTL;
  assign aw_hit = aw_addr == A_CTRL || aw_addr == A_SEEK || aw_addr == A_OFS
    || aw_addr == A_OCTL || aw_addr == A_STAT || aw_addr == A_CNT;
  assign ar_hit = araddr == A_CTRL || araddr == A_SEEK || araddr == A_OFS
    || araddr == A_OCTL || araddr == A_STAT || araddr == A_CNT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      aw_addr <= 8'h00;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        aw_addr <= awaddr;
      end else if (do_wr) begin
        aw_got <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (ce) begin
      if (wvalid && wready) begin
        w_got <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end else if (do_wr) begin
        w_got <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ce) begin
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp <= aw_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= ar_hit ? RESP_OKAY : RESP_SLVERR;
        rdata <= rd_mux;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // software commands
  logic seek_go;
  logic fclr;
  logic ofs_begin;
  logic ofs_clr;
  logic rw_active;
  logic tgt_odd;
  logic [9:0] diff_cnt;
  logic [7:0] ofs_val;
  logic [31:0] ctrl_v;
  logic [31:0] seek_v;
  logic [31:0] seek_m;
  assign seek_go = wr_ctrl & wd[F_SEEK_GO];
  assign fclr = wr_ctrl & wd[F_FCLR];
  assign ofs_begin = wr_octl & wd[F_OFS_BEGIN]; // see R9
  assign ofs_clr = wr_octl & wd[F_OFS_CLR];
  assign ctrl_v = {30'h0, rw_active, 1'b0};
  assign seek_v = {15'h0, tgt_odd, 6'h0, diff_cnt};
  assign seek_m = (seek_v & ~wm) | (w_data & wm);

  // seek sequencing
  ssoc_state_t st;
  ssoc_state_t next_st;
  logic [16:0] inhib_cnt;
  logic [16:0] tmr;
  logic [16:0] next_tmr;
  logic seeking;
  logic t_le1;
  logic inhib_done;
  logic settle_done;
  logic loss;
  logic cyl;
  logic half_edge;
  logic fail_set;
  logic lock_set;
  logic [9:0] togo;
  logic clamp;
  logic ofs_on;
  logic ofs_eng;
  logic next_eng;
  logic ofs_take;
  logic [4:0] ofs_mag;
  logic [6:0] next_pc;
  logic seek_fail;
  logic lockout;
  logic fault_sum;
  logic target_parity_ff;
  logic stop_phase;
  logic outer_band;
  logic inner_band;

  assign seeking = st == st_seek || st == st_settle;
  assign t_le1 = diff_cnt >= CNT_T1; // see R1
  assign stop_phase = seeking & t_le1; // see R1
  assign inhib_done = inhib_cnt == 17'(P_INHIB);
  assign settle_done = tmr == 17'(P_SETTLE);
  assign loss = st == st_on && off_s && tmr == 17'(P_OFFTRK); // see R6
  assign cyl = null_s & ~null_d & seeking & ~ofs_on; // see R13
  assign half_edge = half_s & ~half_d;
  assign fail_set = loss; // see R6
  assign lock_set = loss & rw_active; // see R7
  assign togo = ~diff_cnt; // see R17
  assign clamp = togo >= CLAMP_T;

  always_comb begin
    next_st = st;
    unique case (st)
      st_idle: next_st = st_idle;
      st_seek: if (t_le1 && near_s && inhib_done) next_st = st_settle; // see R4
      st_settle: if (settle_done) next_st = st_on; // see R4
      st_on: if (loss) next_st = st_idle; // see R6
    endcase
    if (seek_go) next_st = st_seek; // see R20
  end

  // one timer serves the settle delay and the off-track window
  assign next_tmr = (seek_go || next_st != st) ? 17'h0 :
    (st == st_settle && off_s) ? 17'h0 : // see R18
    (st == st_on && !off_s) ? 17'h0 :
    (st == st_settle || st == st_on) ? tmr + 17'h1 : 17'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= st_idle;
      tmr <= 17'h0;
      inhib_cnt <= 17'(P_INHIB);
      on_cylinder <= 1'b0;
    end else if (ce) begin
      st <= next_st;
      tmr <= next_tmr;
      inhib_cnt <= seek_go ? 17'h0 : inhib_done ? inhib_cnt : inhib_cnt + 17'h1; // see R4
      on_cylinder <= next_st == st_on; // see R4
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      null_d <= 1'b0;
      half_d <= 1'b0;
      fine_mode <= 1'b0;
      coarse_mode <= 1'b0;
      target_parity_ff <= 1'b0;
      integ_clear <= 1'b0;
      cyl_pulse <= 1'b0;
    end else if (ce) begin
      null_d <= null_s;
      half_d <= half_s;
      // fine stays set through settle and track following
      fine_mode <= seek_go ? 1'b0 : (stop_phase && half_edge) ? 1'b1 : fine_mode; // see R2 R5 R20
      coarse_mode <= seek_go ? 1'b1 : (stop_phase && half_edge) ? 1'b0 : coarse_mode; // see R2 R20
      target_parity_ff <= seek_go ? tgt_odd : target_parity_ff; // see R3
      integ_clear <= cyl; // see R1
      cyl_pulse <= cyl; // see R13
    end
  end
  assign servo_invert = target_parity_ff; // see R3

  // faults: a new event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seek_fail <= 1'b0;
      lockout <= 1'b0;
      fault_sum <= 1'b0;
      heads_select <= 1'b0;
    end else if (ce) begin
      seek_fail <= fail_set | (seek_fail & ~fclr); // see R6
      lockout <= lock_set | (lockout & ~fclr); // see R7
      fault_sum <= lock_set | (fault_sum & ~fclr); // see R7
      heads_select <= seek_go ? 1'b1 : fail_set ? 1'b0 : heads_select; // see R6
    end
  end

  // software registers and counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rw_active <= 1'b0;
      tgt_odd <= 1'b0;
      diff_cnt <= CNT_ALL;
      ofs_val <= 8'h00;
    end else if (ce) begin
      if (wr_ctrl) rw_active <= w_strb[0] ? w_data[F_RW] : rw_active;
      if (wr_seek) begin
        tgt_odd <= seek_m[F_TGT_ODD];
        diff_cnt <= seek_m[9:0]; // see R17
      end else if (cyl && diff_cnt != CNT_ALL) begin
        diff_cnt <= diff_cnt + 10'h001; // see R17 R10
      end
      if (wr_ofs && w_strb[0]) ofs_val <= w_data[7:0];
    end
  end

  // offset handling
  assign next_eng = ofs_begin | (ofs_eng & ~ofs_clr); // see R11
  assign ofs_take = wr_ofs && w_strb[0] && st == st_on && ofs_eng; // see R9

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ofs_eng <= 1'b0;
      ofs_on <= 1'b0;
      ofs_mag <= 5'h00;
      offset_dir <= 1'b0;
    end else if (ce) begin
      ofs_eng <= next_eng; // see R11
      ofs_on <= ofs_take | (ofs_on & next_eng & ~seek_go & (next_st == st_on)); // see R9
      if (ofs_take) begin
        offset_dir <= w_data[F_OFS_DIR]; // see R8
        ofs_mag <= w_data[F_MAG_HI:F_MAG_LO]; // see R8
      end
    end
  end

  // converter holds offset magnitude in offset mode, else tracks to go
  assign next_pc = ofs_on ? {2'b00, ofs_mag} : clamp ? POS_MAX : togo[6:0]; // see R10 R12

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_conv <= POS_MAX;
      pos_clamp <= 1'b0;
      offset_uin <= 10'h000;
    end else if (ce) begin
      pos_conv <= next_pc; // see R12
      pos_clamp <= ~ofs_on & clamp; // see R12
      offset_uin <= ofs_on ? 10'(ofs_mag) * UIN_STEP : 10'h000; // see R19
    end
  end

  ssoc_dibit u_dibit (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pos_sense(s2[0]),
    .neg_sense(s2[1]),
    .odd_dibit(odd_dibit),
    .even_dibit(even_dibit),
    .clk_tick(clk_tick),
    .outer_band(outer_band),
    .inner_band(inner_band),
    .travel_limit(travel_limit)
  ); // see R15 R16

  // read data
  logic [31:0] stat_v;
  assign stat_v = {20'h0, inner_band, outer_band, stop_phase, heads_select, target_parity_ff,
    coarse_mode, fine_mode, fault_sum, lockout, seek_fail, ofs_eng, on_cylinder};
  assign rd_mux = araddr == A_CTRL ? ctrl_v :
    araddr == A_SEEK ? seek_v :
    araddr == A_OFS ? {24'h0, ofs_val} :
    araddr == A_OCTL ? {30'h0, ofs_eng, ofs_on} :
    araddr == A_STAT ? stat_v :
    araddr == A_CNT ? {9'h0, pos_conv, 6'h0, diff_cnt} : 32'h0000_0000;
endmodule
